// ===== verilog/vc3ts_adapt.sv
// Test-signal source and sink for a VC-3 path, with an Avalon-MM register slave.
// Assumes link pins come from outside clk_sys and toggle far slower than it.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
module vc3ts_adapt (
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       path_timing_clock,
    input  wire logic                       path_timing_frame_start,
    input  wire logic                       one_second_tick,
    output vc3ts_pkg::vc3ts_src_link_s      src_link,
    input  wire vc3ts_pkg::vc3ts_snk_link_s snk_link
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_n;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;
    logic       ti_rise;
    logic       ti_fall;
    logic       snk_rise;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_s3 <= 6'h00;
        end else begin
            pin_s1 <= {path_timing_clock, path_timing_frame_start, snk_link.clk,
                       snk_link.fs, snk_link.data, snk_link.tsf};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign ti_rise  = pin_s2[5] & ~pin_s3[5];
    assign ti_fall  = ~pin_s2[5] & pin_s3[5];
    assign snk_rise = pin_s2[3] & ~pin_s3[3];

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic [1:0] ctrl;
    logic       bus_ack;
    logic       src_act;
    logic       snk_act;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= vc3ts_pkg::CTRL_RESET;
        end else if (avs_write && bus_ack && avs_address == vc3ts_pkg::REG_CTRL) begin
            ctrl <= avs_writedata[1:0];
        end
    end
    assign src_act = ctrl[vc3ts_pkg::CTRL_SRC_ACT];
    assign snk_act = ctrl[vc3ts_pkg::CTRL_SNK_ACT];

    // ----------------------------------------------------------------
    // Source: sequence generator and frame builder
    // ----------------------------------------------------------------
    vc3ts_pkg::vc3ts_pos_s src_pos;
    vc3ts_pkg::vc3ts_pos_s src_cur;
    logic [22:0]           gen_sr;
    logic                  gen_fb;

    assign src_cur = pin_s2[4] ? '0 : src_pos;
    assign gen_fb  = vc3ts_pkg::vc3ts_fb(gen_sr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_pos <= '0;
        end else if (ti_rise) begin
            src_pos <= vc3ts_pkg::vc3ts_step(src_cur);
        end
    end

    // Never reloaded at frame start, so the sequence drifts across frames
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gen_sr <= vc3ts_pkg::PRBS_SEED;
        end else if (ti_rise && src_cur.col != 7'h00) begin // [RULE1] [RULE2]
            gen_sr <= {gen_sr[21:0], gen_fb}; // [RULE16]
        end
    end

    // Data changes on the falling edge of the output clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_link <= '0;
        end else begin
            // Output clock moves only on a seen timing edge: no rise without a bit
            if (ti_rise) begin
                src_link.clk <= 1'b0;
            end else if (ti_fall) begin
                src_link.clk <= 1'b1;
            end
            src_link.data_oe <= src_act; // [RULE5]
            if (ti_rise && src_act) begin // [RULE5]
                src_link.fs <= (src_cur == '0);
                if (src_cur.col != 7'h00) begin
                    src_link.data <= ~gen_fb; // [RULE1] [RULE16]
                end else if (src_cur.row == vc3ts_pkg::ROW_C2) begin
                    src_link.data <= vc3ts_pkg::LABEL_TEST[3'h7 - src_cur.bit_idx]; // [RULE3]
                end else begin
                    src_link.data <= 1'b0; // [RULE4]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sink: frame position, label capture and acceptance
    // ----------------------------------------------------------------
    vc3ts_pkg::vc3ts_pos_s snk_pos;
    vc3ts_pkg::vc3ts_pos_s snk_cur;
    logic                  rx_bit;
    logic [6:0]            c2_shift;
    logic [7:0]            c2_byte;
    logic [7:0]            c2_prev;
    logic [2:0]            c2_run;
    logic [7:0]            accepted_signal_label;
    logic                  payload_bit;

    assign snk_cur     = pin_s2[2] ? '0 : snk_pos;
    assign rx_bit      = pin_s2[1];
    assign payload_bit = snk_rise && snk_cur.col != 7'h00; // [RULE6]
    assign c2_byte     = {c2_shift, rx_bit};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snk_pos <= '0;
        end else if (snk_rise) begin
            snk_pos <= vc3ts_pkg::vc3ts_step(snk_cur); // [RULE6]
        end
    end

    // Only the C2 row is captured; H4 and other overhead pass unread
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            c2_shift              <= 7'h00;
            c2_prev               <= 8'h00;
            c2_run                <= 3'h0;
            accepted_signal_label <= 8'h00;
        end else if (snk_rise && snk_cur.col == 7'h00
                     && snk_cur.row == vc3ts_pkg::ROW_C2) begin // [RULE8]
            c2_shift <= c2_byte[6:0];
            if (snk_cur.bit_idx == 3'h7) begin
                c2_prev <= c2_byte;
                if (c2_byte != c2_prev) begin
                    c2_run <= 3'h1;
                end else if (c2_run != vc3ts_pkg::ACCEPT_FRAMES) begin
                    c2_run <= c2_run + 3'h1;
                end
                if (c2_byte == c2_prev && c2_run + 3'h1 >= vc3ts_pkg::ACCEPT_FRAMES) begin
                    accepted_signal_label <= c2_byte; // [RULE7]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sink: self-synchronising checker and lock detector
    // ----------------------------------------------------------------
    logic [22:0] chk_sr;
    logic        chk_err;
    logic        locked;
    logic [6:0]  clean_run;
    logic [9:0]  win_cnt;
    logic [9:0]  win_errs;
    logic        test_sequence_error;

    assign chk_err = rx_bit ^ ~vc3ts_pkg::vc3ts_fb(chk_sr); // [RULE16]
    assign test_sequence_error = payload_bit && locked && chk_err; // [RULE9]

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chk_sr <= 23'h000000;
        end else if (payload_bit) begin
            chk_sr <= {chk_sr[21:0], ~rx_bit}; // [RULE16]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            locked    <= 1'b0;
            clean_run <= 7'h00;
            win_cnt   <= 10'h000;
            win_errs  <= 10'h000;
        end else if (payload_bit) begin
            if (!locked) begin
                clean_run <= chk_err ? 7'h00 : clean_run + 7'h01;
                if (!chk_err && clean_run == vc3ts_pkg::SYNC_RUN - 7'h01) begin
                    locked   <= 1'b1;
                    win_cnt  <= 10'h000;
                    win_errs <= 10'h000;
                end
            end else if (win_cnt == vc3ts_pkg::WIN_BITS - 10'h001) begin
                win_cnt   <= 10'h000;
                win_errs  <= 10'h000;
                clean_run <= 7'h00;
                if (win_errs + {9'h000, chk_err} >= vc3ts_pkg::LOSS_ERRS) begin
                    locked <= 1'b0; // [RULE12]
                end
            end else begin
                win_cnt  <= win_cnt + 10'h001;
                win_errs <= win_errs + {9'h000, chk_err};
            end
        end
    end

    // ----------------------------------------------------------------
    // Sink: per-second error total and correlated reports
    // ----------------------------------------------------------------
    logic [31:0] err_acc;
    logic [31:0] near_end_error_total;
    logic        label_mismatch_defect;
    logic        sequence_lock_loss_defect;
    logic        label_mismatch_report;
    logic        lock_loss_report;
    logic        incoming_trail_fail;

    // An error in the tick cycle opens the new interval
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_acc              <= 32'h00000000;
            near_end_error_total <= 32'h00000000;
        end else if (one_second_tick) begin
            near_end_error_total <= err_acc; // [RULE15] [RULE17]
            err_acc              <= {31'h00000000, test_sequence_error};
        end else if (test_sequence_error && err_acc != 32'hFFFFFFFF) begin
            err_acc <= err_acc + 32'h00000001; // [RULE15]
        end
    end

    assign incoming_trail_fail       = pin_s2[0];
    assign label_mismatch_defect     = accepted_signal_label != vc3ts_pkg::LABEL_TEST; // [RULE11]
    assign sequence_lock_loss_defect = ~locked; // [RULE12]
    assign label_mismatch_report = snk_act && label_mismatch_defect
                                   && !incoming_trail_fail; // [RULE13] [RULE10]
    assign lock_loss_report      = snk_act && sequence_lock_loss_defect
                                   && !incoming_trail_fail; // [RULE14] [RULE10]

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ----------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !bus_ack) begin
            unique case (avs_address)
                vc3ts_pkg::REG_CTRL: begin
                    avs_readdata <= {30'h00000000, ctrl};
                end
                vc3ts_pkg::REG_STATUS: begin
                    avs_readdata <= {28'h0000000, snk_act && locked,
                                     snk_act && incoming_trail_fail, // [RULE10]
                                     lock_loss_report, label_mismatch_report};
                end
                vc3ts_pkg::REG_LABEL: begin
                    avs_readdata <= {24'h000000, snk_act ? accepted_signal_label
                                                         : 8'h00}; // [RULE7] [RULE10]
                end
                vc3ts_pkg::REG_TOTAL: begin
                    avs_readdata <= snk_act ? near_end_error_total
                                            : 32'h00000000; // [RULE10]
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                end
            endcase
        end
    end
endmodule : vc3ts_adapt
`default_nettype wire

// ===== verilog/vc3ts_pkg.sv
// Constants, link carriers and frame helpers for the VC-3 test-signal adapter.
// Assumes a single system clock; link pins are sampled by the top module.
// Notes on behaviour
// RULE1: Source makes a 2^23 pseudo-random sequence filling all 756 payload bytes.
// RULE2: Source sequence runs on across frames and never restarts at frame start.
// RULE3: Source writes label 1111 1110 into the C2 byte of every frame.
// RULE4: Source may put any value in H4.
// RULE5: Source drives its adaptation output only while activated.
// RULE6: Sink extracts the sequence using received clock and frame start.
// RULE7: Sink compares accepted C2 label with 1111 1110 and exposes it.
// RULE8: Sink ignores the H4 byte.
// RULE9: Sink counts mismatching payload bits as errors only while locked.
// RULE10: Sink reports status only while activated.
// RULE11: Sink flags label mismatch when accepted label differs from expected.
// RULE12: Sink flags loss of sequence lock when its detector falls out of lock.
// RULE13: Label mismatch report needs the defect and no incoming trail fail.
// RULE14: Lock loss report needs the defect and no incoming trail fail.
// RULE15: Sink totals errors per one-second interval as the near-end count.
// RULE16: Twenty-three stage register, taps 23 and 18, inverted output, self-synchronising.
// RULE17: Management pulses the tick one cycle per second; total latched, accumulator cleared. Code loads the accumulator with the tick cycle's error bit.
`default_nettype none
package vc3ts_pkg;
    // Frame geometry: 9 rows of 85 columns, column 0 is path overhead
    localparam logic [3:0]  LAST_ROW = 4'h8;
    localparam logic [6:0]  LAST_COL = 7'h54;
    localparam logic [3:0]  ROW_C2   = 4'h2;
    localparam logic [7:0]  LABEL_TEST = 8'hFE;
    localparam logic [22:0] PRBS_SEED  = 23'h7FFFFF;
    localparam int          TAP_A = 22;
    localparam int          TAP_B = 17;
    // Label acceptance and lock criteria
    localparam logic [2:0]  ACCEPT_FRAMES = 3'h5;
    localparam logic [6:0]  SYNC_RUN      = 7'h40;
    localparam logic [9:0]  WIN_BITS      = 10'h3E8;
    localparam logic [9:0]  LOSS_ERRS     = 10'h064;
    // Register map, byte addresses
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam logic [3:0]  REG_LABEL  = 4'h8;
    localparam logic [3:0]  REG_TOTAL  = 4'hC;
    localparam int          CTRL_SRC_ACT = 0;
    localparam int          CTRL_SNK_ACT = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;

    typedef struct packed {
        logic [3:0] row;
        logic [6:0] col;
        logic [2:0] bit_idx;
    } vc3ts_pos_s;

    typedef struct packed {
        logic clk;
        logic fs;
        logic data;
        logic data_oe;
    } vc3ts_src_link_s;

    typedef struct packed {
        logic clk;
        logic fs;
        logic data;
        logic tsf;
    } vc3ts_snk_link_s;

    function automatic vc3ts_pos_s vc3ts_step(input vc3ts_pos_s p);
        vc3ts_pos_s n;
        n = p;
        n.bit_idx = p.bit_idx + 3'h1;
        if (p.bit_idx == 3'h7) begin
            n.col = (p.col == LAST_COL) ? 7'h00 : p.col + 7'h01;
            if (p.col == LAST_COL) begin
                n.row = (p.row == LAST_ROW) ? 4'h0 : p.row + 4'h1;
            end
        end
        return n;
    endfunction : vc3ts_step

    function automatic logic vc3ts_fb(input logic [22:0] s);
        return s[TAP_A] ^ s[TAP_B];
    endfunction : vc3ts_fb
endpackage : vc3ts_pkg
`default_nettype wire

// ===== tb/vc3ts_adapt_assertions.sv
// Checker for the VC-3 test-signal adapter: bus handshake and link output timing.
// Assumes it is bound to vc3ts_adapt and sees only that module's ports.
`default_nettype none
module vc3ts_adapt_assertions (
    input wire logic                       clk_sys,
    input wire logic                       arst_n,
    input wire logic [3:0]                 avs_address,
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic [31:0]                avs_readdata,
    input wire logic                       avs_waitrequest,
    input wire vc3ts_pkg::vc3ts_src_link_s src_link
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    logic rd_done;
    assign rd_done = avs_read && !avs_waitrequest;

    sequence one_wait_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    wait_state_a: assert property ($rose(avs_read || avs_write) |-> one_wait_s)
        else $error("bus answer not after one wait state");
    idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    unmapped_zero_a: assert property (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_width_a: assert property (rd_done && avs_address == 4'h0 |-> avs_readdata[31:2] == 30'h0)
        else $error("control register has extra bits");
    label_width_a: assert property (rd_done && avs_address == 4'h8 |-> avs_readdata[31:8] == 24'h0)
        else $error("label wider than a byte");
    fail_masks_a: assert property (rd_done && avs_address == 4'h4 && avs_readdata[2] |-> avs_readdata[1:0] == 2'h0)
        else $error("report shown under trail fail");
    idle_hold_a: assert property (!src_link.data_oe && !$past(src_link.data_oe) |-> $stable(src_link.data) && $stable(src_link.fs))
        else $error("inactive source changed its output");
    data_on_low_a: assert property ($changed(src_link.data) || $changed(src_link.fs) |-> !src_link.clk)
        else $error("source data changed while link clock high");
    data_stands_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule : vc3ts_adapt_assertions

bind vc3ts_adapt vc3ts_adapt_assertions u_chk (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .src_link(src_link)
);
`default_nettype wire

// ===== tb/vc3ts_path_model.sv
// Path trail termination model: makes the timing clock and frame start,
// loops the source link back to the sink link, can corrupt bits on demand.
`default_nettype none
module vc3ts_path_model (
    input  wire logic                       clk_sys,
    input  wire vc3ts_pkg::vc3ts_src_link_s src_link,
    input  wire logic                       inv,
    input  wire logic                       one_err,
    input  wire logic                       tsf,
    output logic                            tclk,
    output logic                            tfs,
    output vc3ts_pkg::vc3ts_snk_link_s      snk_link,
    output logic [7:0]                      c2_seen,
    output logic [7:0]                      frames
);
    timeunit 1ns;
    timeprecision 1ns;
    int   tcnt = 0;
    int   pos = 0;
    int   cur;
    int   col;
    logic pc = 1'b0;
    logic pend = 1'b0;
    logic flip;

    initial begin
        tclk = 1'b0;
        c2_seen = 8'h00;
        frames = 8'h00;
        snk_link = '0;
        #7;
        forever #160 tclk = ~tclk;
    end

    always @(negedge tclk) tcnt <= (tcnt == 6119) ? 0 : tcnt + 1;
    assign tfs = (tcnt == 0);

    assign cur  = src_link.fs ? 0 : pos;
    assign col  = (cur / 8) % 85;
    // H4 bits are spoiled on purpose; payload bits on request
    assign flip = (cur >= 3400 && cur < 3408) || (col != 0 && (inv || pend));

    always @(posedge clk_sys) begin
        pc <= src_link.clk;
        snk_link.clk <= pc;
        snk_link.tsf <= tsf;
        if (one_err) pend <= 1'b1;
        if (src_link.clk && !pc) begin
            snk_link.data <= src_link.data_oe ? src_link.data ^ flip : ~snk_link.data;
            snk_link.fs <= src_link.fs;
            pos <= cur + 1;
            if (cur >= 1360 && cur < 1368) c2_seen <= {c2_seen[6:0], src_link.data};
            if (src_link.fs) frames <= frames + 8'h01;
            if (col != 0 && !one_err) pend <= 1'b0;
        end
    end
endmodule : vc3ts_path_model
`default_nettype wire

// ===== tb/test_vc3ts_adapt.sv
// Testbench for the VC-3 test-signal adapter, looped back through the path model.
// Assumes a 25 MHz clk_sys and a 320 ns path timing clock.
`default_nettype none
module test_vc3ts_adapt;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tclk;
    logic        tfs;
    logic        tick = 1'b0;
    logic        inv = 1'b0;
    logic        one_err = 1'b0;
    logic        tsf = 1'b0;
    logic [7:0]  c2_seen;
    logic [7:0]  frames;
    logic [31:0] got;
    int          fail_count = 0;
    int          checks_done = 0;
    vc3ts_pkg::vc3ts_src_link_s src_link;
    vc3ts_pkg::vc3ts_snk_link_s snk_link;

    always #20 clk_sys = ~clk_sys;

    vc3ts_adapt dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .path_timing_clock(tclk), .path_timing_frame_start(tfs),
        .one_second_tick(tick), .src_link(src_link), .snk_link(snk_link));
    vc3ts_path_model u_path (.clk_sys(clk_sys), .src_link(src_link), .inv(inv),
        .one_err(one_err), .tsf(tsf), .tclk(tclk), .tfs(tfs), .snk_link(snk_link),
        .c2_seen(c2_seen), .frames(frames));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_word

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        got = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check_word(what, exp, got);
    endtask : rd_chk

    task automatic wait_bits(input int n);
        repeat (n * 8) @(posedge clk_sys);
    endtask : wait_bits

    task automatic pulse(input logic sel_err);
        @(posedge clk_sys);
        if (sel_err) begin
            one_err <= 1'b1;
        end else begin
            tick <= 1'b1;
        end
        @(posedge clk_sys);
        one_err <= 1'b0;
        tick <= 1'b0;
    endtask : pulse

    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(4'h0, 32'h0, "ctrl reset");
        rd_chk(4'h4, 32'h0, "status reset");
        rd_chk(4'h8, 32'h0, "label reset");
        rd_chk(4'hC, 32'h0, "total reset");
        bus(1'b1, 4'h5, 32'hFFFFFFFF);
        rd_chk(4'h6, 32'h0, "unmapped read");
        rd_chk(4'h0, 32'h0, "ctrl after unmapped write");
        bus(1'b1, 4'h0, 32'hFFFFFFFF);
        rd_chk(4'h0, 32'h3, "ctrl bits");
        wait_bits(300);
        rd_chk(4'h4, 32'h9, "locked with label mismatch");
        tsf <= 1'b1;
        wait_bits(2);
        rd_chk(4'h4, 32'hC, "status under trail fail");
        // Trail fail stays up: an inactive sink must hide it as well
        bus(1'b1, 4'h0, 32'h1);
        rd_chk(4'h4, 32'h0, "status sink off");
        rd_chk(4'hC, 32'h0, "total sink off");
        tsf <= 1'b0;
        bus(1'b1, 4'h0, 32'h3);
        pulse(1'b0);
        pulse(1'b1);
        wait_bits(100);
        pulse(1'b0);
        // One flipped bit is met again as it passes both feedback taps
        rd_chk(4'hC, 32'h3, "total one error");
        pulse(1'b0);
        wait_bits(1);
        rd_chk(4'hC, 32'h0, "total clean interval");
        inv <= 1'b1;
        wait_bits(1500);
        rd_chk(4'h4, 32'h3, "lock lost");
        pulse(1'b0);
        wait_bits(300);
        pulse(1'b0);
        rd_chk(4'hC, 32'h0, "no count out of lock");
        tsf <= 1'b1;
        wait_bits(2);
        rd_chk(4'h4, 32'h4, "lock loss masked");
        tsf <= 1'b0;
        inv <= 1'b0;
        wait_bits(300);
        rd_chk(4'h4, 32'h9, "relocked");
        pulse(1'b0);
        for (int n = 0; n < 70000 && frames < 8'h01; n++) @(posedge clk_sys);
        check_word("frame start seen", 32'h1, {31'h0, frames != 8'h00});
        wait_bits(2100);
        pulse(1'b0);
        rd_chk(4'hC, 32'h0, "clean across frame and H4");
        check_word("C2 byte", 32'hFE, {24'h0, c2_seen});
        bus(1'b1, 4'h0, 32'h2);
        wait_bits(4);
        check_word("source enable off", 32'h0, {31'h0, src_link.data_oe});
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        check_word("watchdog", 32'h0, 32'h1);
        finish_test();
    end
endmodule : test_vc3ts_adapt
`default_nettype wire
